//--- src/fcpp_pkg.sv
package fcpp_pkg;
    // command bytes
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
    localparam logic [7:0] CMD_WRITE_FUSE = 8'h40;
    localparam logic [7:0] CMD_WRITE_LOCK = 8'h20;
    localparam logic [7:0] CMD_READ_SIG   = 8'h08;
    localparam logic [7:0] CMD_READ_FUSE  = 8'h04;
    // pulse actions on {hi, lo}
    localparam logic [1:0] ACT_LOAD_ADDR = 2'h0;
    localparam logic [1:0] ACT_LOAD_DATA = 2'h1;
    localparam logic [1:0] ACT_LOAD_CMD  = 2'h2;
    // byte selection on {upper, half}
    localparam logic [1:0] SEL_LOW  = 2'h0;
    localparam logic [1:0] SEL_HIGH = 2'h1;
    localparam logic [1:0] SEL_EXT  = 2'h2;
    localparam logic [1:0] SEL_LOCK = 2'h3;
    // factory values, programmed bits are 0
    localparam logic [7:0] EXT_RESET  = 8'hff;
    localparam logic [7:0] HIGH_RESET = 8'h99;
    localparam logic [7:0] LOW_RESET  = 8'h62;
    localparam logic [7:0] LOCK_RESET = 8'hff;
    // field positions
    localparam int EXT_BROWNOUT_LO   = 1;
    localparam int EXT_RESET_DISABLE = 0;
    localparam int HI_DEBUG          = 7;
    localparam int HI_BOUNDARY       = 6;
    localparam int HI_SERIAL_DL      = 5;
    localparam int HI_WATCHDOG       = 4;
    localparam int HI_KEEP_EEPROM    = 3;
    localparam int HI_BOOT_LO        = 1;
    localparam int HI_RESET_VECTOR   = 0;
    localparam int LO_PRESCALE8      = 7;
    localparam int LO_CLOCK_PIN      = 6;
    localparam int LO_STARTUP_LO     = 4;
    localparam int LO_CLKSRC_LO      = 0;
    localparam int LOCK_FIRST        = 0;
    // decodes
    localparam logic [3:0] CLKSRC_RC8      = 4'h2;
    localparam logic [1:0] STARTUP_LONGEST = 2'h2;
    localparam logic [1:0] BOOT_LARGEST    = 2'h0;
    // signature addresses
    localparam logic [7:0] SIG_ADDR0 = 8'h00;
    localparam logic [7:0] SIG_ADDR1 = 8'h01;
    localparam logic [7:0] SIG_ADDR2 = 8'h02;
    // timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int PULSE_MIN_NS  = 250;
    localparam int PULSE_MIN_CYC = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROG_TIME_NS  = 1000;
    localparam logic [15:0] PROG_CYC = 16'(PROG_TIME_NS / CLK_PERIOD_NS);

    typedef struct packed {
        logic       progEnable;
        logic       serialPath;
        logic       crystalInputOne;
        logic       writeN;
        logic       outEnableN;
        logic       bufferLoadStrobe;
        logic       byteHalfSelect;
        logic       upperByteSelect;
        logic       pulseActionSelHi;
        logic       pulseActionSelLo;
        logic [7:0] data;
    } fcpp_pins_s;

    localparam fcpp_pins_s PINS_IDLE = '{writeN: 1'b1, outEnableN: 1'b1, default: '0};

    typedef struct packed {
        logic [7:0] ext;
        logic [7:0] high;
        logic [7:0] low;
    } fcpp_fuse_s;

    localparam fcpp_fuse_s FUSE_RESET = '{ext: EXT_RESET, high: HIGH_RESET, low: LOW_RESET};

    typedef struct packed {
        logic debugClockInSleep;
        logic clockPinDrive;
        logic rcEightMhz;
        logic startupLongest;
        logic bootAreaLargest;
        logic prescaleByEight;
        logic watchdogForced;
        logic boundaryPortOn;
        logic extResetOff;
        logic resetVectorBoot;
    } fcpp_flags_s;
endpackage : fcpp_pkg

//--- src/fcpp_prog_port.sv
`timescale 1ns/10ps

// Behaviour
// - chip erase leaves fuse bytes untouched
// - first lock bit programmed refuses fuse writes
// - latch fuses on mode entry, hold
// - keep-eeprom fuse acts immediately
// - latches load from stored fuses at power-up
// - three signature bytes readable, even locked
// - reset copies calibration byte into trim
// - crystal pulse performs selected load action
// - write strobe runs loaded command; output strobe only drives read data
// - ready flag low while busy, high ready
// - data pins driven only while output-enable low
// - half select picks low or high byte
// - upper select picks second high byte
// - buffer load strobe fills page buffer
// - serial path cannot read or write serial-download fuse
// - debug fuse keeps clocks running in sleep
// - default clock source is 8 MHz RC, longest start
// - clock-output fuse drives system clock pin
// - boot-size bits both zero give largest area
// - programmed fuse reads 0, unprogrammed 1
// - action codes: address, data, command, idle
// - decode erase, fuse, lock, signature, fuse-read commands
module fcpp_prog_port #(
    parameter logic [7:0] SIG_BYTE0  = 8'h5a, // arbitrary identification value
    parameter logic [7:0] SIG_BYTE1  = 8'h01, // arbitrary identification value
    parameter logic [7:0] SIG_BYTE2  = 8'h02, // arbitrary identification value
    parameter logic [7:0] CAL_BYTE   = 8'h80,
    parameter int         PAGE_DEPTH = 8
) (
    // clock, reset, enable
    input  wire logic                 ref_clk,
    input  wire logic                 srst,
    input  wire logic                 clkEn,
    // programming pins, asynchronous
    input  wire fcpp_pkg::fcpp_pins_s pinsIn,
    // data pins and handshake
    output logic [7:0]                dataOut,
    output logic                      dataOe,
    output logic                      progReadyFlag,
    // fuse state toward the rest of the chip
    output fcpp_pkg::fcpp_fuse_s      fuseLatch,
    output fcpp_pkg::fcpp_flags_s     fuseFlags,
    output logic [7:0]                rcTrimRegister,
    output logic [7:0]                lockByte,
    // memory side
    output logic                      memEraseStrobe,
    output logic                      eepromEraseStrobe,
    output logic [7:0]                pageWord
);
    localparam int IDXW = (PAGE_DEPTH > 1) ? $clog2(PAGE_DEPTH) : 1;

    fcpp_pkg::fcpp_pins_s pinS1_r, pinS2_r, pinS3_r, pin_r, pinPrev_r;
    fcpp_pkg::fcpp_fuse_s store_r, latch_r;
    fcpp_pkg::fcpp_flags_s flags_r;
    logic [7:0]  addrLo_r, addrHi_r, dataLo_r, dataHi_r, cmd_r, lock_r, trim_r;
    logic [7:0]  dataOut_r, pageWord_r, readVal;
    logic [7:0]  pageBuf_r [PAGE_DEPTH];
    logic [15:0] busyCnt_r;
    logic        progMode_r, loadPend_r, dataOe_r, ready_r, memErase_r, eeErase_r;
    logic        xtalRise, wrFall, pagelRise, modeEnter, modeLeave, start;
    logic        fuseWrite;
    logic [1:0]  sel;

    // byte choice shared by fuse write and read paths
    function automatic logic [1:0] byteSel(input logic half, input logic upper);
        byteSel = {upper, half};
    endfunction : byteSel

    ////////////////////////////////////////////////////////////////////////////
    // pin synchroniser: a bit changes once stages two and three agree
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pinS1_r   <= fcpp_pkg::PINS_IDLE;
            pinS2_r   <= fcpp_pkg::PINS_IDLE;
            pinS3_r   <= fcpp_pkg::PINS_IDLE;
            pin_r     <= fcpp_pkg::PINS_IDLE;
            pinPrev_r <= fcpp_pkg::PINS_IDLE;
        end else if (clkEn) begin
            pinS1_r   <= pinsIn;
            pinS2_r   <= pinS1_r;
            pinS3_r   <= pinS2_r;
            pin_r     <= (pinS2_r & pinS3_r) | (pin_r & (pinS2_r | pinS3_r));
            pinPrev_r <= pin_r;
        end
    end

    // edges are taken on the filtered copy, so glitches shorter than a cycle vanish
    assign xtalRise  = pin_r.crystalInputOne & ~pinPrev_r.crystalInputOne;
    assign wrFall    = ~pin_r.writeN & pinPrev_r.writeN;
    assign pagelRise = pin_r.bufferLoadStrobe & ~pinPrev_r.bufferLoadStrobe;
    assign modeEnter = pin_r.progEnable & ~pinPrev_r.progEnable & ~progMode_r;
    assign modeLeave = ~pin_r.progEnable & progMode_r;
    assign sel       = byteSel(pin_r.byteHalfSelect, pin_r.upperByteSelect);
    assign start     = wrFall & progMode_r & ready_r;
    assign fuseWrite = start & (cmd_r == fcpp_pkg::CMD_WRITE_FUSE)
                       & lock_r[fcpp_pkg::LOCK_FIRST];

    ////////////////////////////////////////////////////////////////////////////
    // mode entry only with strobe, both actions and half select low
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            progMode_r <= 1'b0;
        end else if (clkEn) begin
            if (modeEnter && !pin_r.bufferLoadStrobe && !pin_r.pulseActionSelHi
                && !pin_r.pulseActionSelLo && !pin_r.byteHalfSelect) begin
                progMode_r <= 1'b1;
            end else if (modeLeave) begin
                progMode_r <= 1'b0;
            end
        end
    end

    // crystal pulse loads address, data or command; code 11 is idle
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            addrLo_r <= '0;
            addrHi_r <= '0;
            dataLo_r <= '0;
            dataHi_r <= '0;
            cmd_r    <= '0;
        end else if (clkEn && progMode_r && xtalRise) begin
            case ({pin_r.pulseActionSelHi, pin_r.pulseActionSelLo})
                fcpp_pkg::ACT_LOAD_ADDR: begin
                    if (pin_r.byteHalfSelect) begin
                        addrHi_r <= pin_r.data;
                    end else begin
                        addrLo_r <= pin_r.data;
                    end
                end
                fcpp_pkg::ACT_LOAD_DATA: begin
                    if (pin_r.byteHalfSelect) begin
                        dataHi_r <= pin_r.data;
                    end else begin
                        dataLo_r <= pin_r.data;
                    end
                end
                fcpp_pkg::ACT_LOAD_CMD: begin
                    cmd_r <= pin_r.data;
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // busy counter; a new strobe while busy is ignored
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            busyCnt_r <= '0;
            ready_r   <= 1'b1;
        end else if (clkEn) begin
            if (start) begin
                busyCnt_r <= fcpp_pkg::PROG_CYC;
                ready_r   <= 1'b0;
            end else if (busyCnt_r != '0) begin
                busyCnt_r <= busyCnt_r - 16'h0001;
                ready_r   <= (busyCnt_r == 16'h0001);
            end
        end
    end

    // stored fuses: only the write command reaches them, erase has no path here
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            store_r <= fcpp_pkg::FUSE_RESET;
        end else if (clkEn && fuseWrite) begin
            case (sel)
                fcpp_pkg::SEL_LOW: store_r.low <= dataLo_r;
                fcpp_pkg::SEL_HIGH: begin
                    store_r.high <= dataLo_r;
                    if (pin_r.serialPath) begin
                        store_r.high[fcpp_pkg::HI_SERIAL_DL] <= store_r.high[fcpp_pkg::HI_SERIAL_DL];
                    end
                end
                fcpp_pkg::SEL_EXT: store_r.ext <= dataLo_r;
                default: begin
                end
            endcase
        end
    end

    // lock bits only ever go to programmed, erase returns them all
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            lock_r     <= fcpp_pkg::LOCK_RESET;
            memErase_r <= 1'b0;
            eeErase_r  <= 1'b0;
        end else if (clkEn) begin
            memErase_r <= start && (cmd_r == fcpp_pkg::CMD_CHIP_ERASE);
            // the stored value is used so a fresh keep-eeprom fuse applies at once
            eeErase_r  <= start && (cmd_r == fcpp_pkg::CMD_CHIP_ERASE)
                          && store_r.high[fcpp_pkg::HI_KEEP_EEPROM];
            if (start && cmd_r == fcpp_pkg::CMD_CHIP_ERASE) begin
                lock_r <= fcpp_pkg::LOCK_RESET;
            end else if (start && cmd_r == fcpp_pkg::CMD_WRITE_LOCK) begin
                lock_r <= lock_r & dataLo_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // working latches: loaded after power-up and on mode entry and exit; the keep-eeprom bit follows the store every cycle
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            latch_r    <= fcpp_pkg::FUSE_RESET;
            loadPend_r <= 1'b1;
        end else if (clkEn) begin
            loadPend_r <= 1'b0;
            if (loadPend_r || modeEnter || modeLeave) begin
                latch_r <= store_r;
            end else begin
                latch_r.high[fcpp_pkg::HI_KEEP_EEPROM] <= store_r.high[fcpp_pkg::HI_KEEP_EEPROM];
            end
        end
    end

    // trim is forced on every reset; nothing else writes it here
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            trim_r <= CAL_BYTE;
        end
    end

    // decoded fuse effects, programmed means 0
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            flags_r <= '0;
        end else if (clkEn) begin
            flags_r.debugClockInSleep <= ~latch_r.high[fcpp_pkg::HI_DEBUG];
            flags_r.clockPinDrive     <= ~latch_r.low[fcpp_pkg::LO_CLOCK_PIN];
            flags_r.rcEightMhz        <= latch_r.low[fcpp_pkg::LO_CLKSRC_LO +: 4] == fcpp_pkg::CLKSRC_RC8;
            flags_r.startupLongest    <= latch_r.low[fcpp_pkg::LO_CLKSRC_LO +: 4] == fcpp_pkg::CLKSRC_RC8
                && latch_r.low[fcpp_pkg::LO_STARTUP_LO +: 2] == fcpp_pkg::STARTUP_LONGEST;
            flags_r.bootAreaLargest   <= latch_r.high[fcpp_pkg::HI_BOOT_LO +: 2] == fcpp_pkg::BOOT_LARGEST;
            flags_r.prescaleByEight   <= ~latch_r.low[fcpp_pkg::LO_PRESCALE8];
            flags_r.watchdogForced    <= ~latch_r.high[fcpp_pkg::HI_WATCHDOG];
            flags_r.boundaryPortOn    <= ~latch_r.high[fcpp_pkg::HI_BOUNDARY];
            flags_r.extResetOff       <= ~latch_r.ext[fcpp_pkg::EXT_RESET_DISABLE];
            flags_r.resetVectorBoot   <= ~latch_r.high[fcpp_pkg::HI_RESET_VECTOR];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read mux; signature space ignores the lock bits
    always_comb begin
        readVal = 8'hff;
        if (cmd_r == fcpp_pkg::CMD_READ_SIG) begin
            if (pin_r.byteHalfSelect) begin
                readVal = CAL_BYTE; // calibration is returned for the high byte at any address
            end else begin
                case (addrLo_r)
                    fcpp_pkg::SIG_ADDR0: readVal = SIG_BYTE0;
                    fcpp_pkg::SIG_ADDR1: readVal = SIG_BYTE1;
                    fcpp_pkg::SIG_ADDR2: readVal = SIG_BYTE2;
                    default:             readVal = 8'h00;
                endcase
            end
        end else if (cmd_r == fcpp_pkg::CMD_READ_FUSE) begin
            case (sel)
                fcpp_pkg::SEL_LOW:  readVal = store_r.low;
                fcpp_pkg::SEL_HIGH: begin
                    readVal = store_r.high;
                    readVal[fcpp_pkg::HI_SERIAL_DL] = store_r.high[fcpp_pkg::HI_SERIAL_DL]
                                                      | pin_r.serialPath;
                end
                fcpp_pkg::SEL_EXT:  readVal = store_r.ext;
                default:            readVal = lock_r;
            endcase
        end
    end

    // data pins follow output enable one cycle behind the filtered pin
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            dataOe_r  <= 1'b0;
            dataOut_r <= '0;
        end else if (clkEn) begin
            dataOe_r  <= progMode_r & ~pin_r.outEnableN;
            dataOut_r <= readVal;
        end
    end

    // page buffer, indexed by the low address bits
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pageWord_r <= '0;
        end else if (clkEn) begin
            if (progMode_r && pagelRise) begin
                pageBuf_r[addrLo_r[IDXW-1:0]] <= dataLo_r;
            end
            pageWord_r <= pageBuf_r[addrLo_r[IDXW-1:0]];
        end
    end

    assign dataOut           = dataOut_r;
    assign dataOe            = dataOe_r;
    assign progReadyFlag     = ready_r;
    assign fuseLatch         = latch_r;
    assign fuseFlags         = flags_r;
    assign rcTrimRegister    = trim_r;
    assign lockByte          = lock_r;
    assign memEraseStrobe    = memErase_r;
    assign eepromEraseStrobe = eeErase_r;
    assign pageWord          = pageWord_r;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_erase_taken;
        clkEn && start && cmd_r == fcpp_pkg::CMD_CHIP_ERASE;
    endsequence

    sequence s_locked_write;
        clkEn && start && cmd_r == fcpp_pkg::CMD_WRITE_FUSE && !lock_r[fcpp_pkg::LOCK_FIRST];
    endsequence

    a_erase_keeps_fuse: assert property (@(posedge ref_clk) disable iff (srst)
        s_erase_taken |=> $stable(store_r) ##1 lock_r == fcpp_pkg::LOCK_RESET)
        else $error("chip erase touched fuses or kept locks");
    a_locked_refuse: assert property (@(posedge ref_clk) disable iff (srst)
        s_locked_write |=> $stable(store_r))
        else $error("fuse write taken while locked");
    a_latch_hold: assert property (@(posedge ref_clk) disable iff (srst)
        progMode_r && $past(progMode_r) && !loadPend_r && $past(clkEn) && !$past(modeLeave)
        |-> latch_r.low == $past(latch_r.low) && latch_r.ext == $past(latch_r.ext))
        else $error("latch changed inside programming mode");
    a_keep_ee_now: assert property (@(posedge ref_clk) disable iff (srst)
        clkEn && $changed(store_r.high[fcpp_pkg::HI_KEEP_EEPROM])
        |=> latch_r.high[fcpp_pkg::HI_KEEP_EEPROM] == store_r.high[fcpp_pkg::HI_KEEP_EEPROM])
        else $error("keep-eeprom fuse did not act at once");
    a_trim_reset: assert property (@(posedge ref_clk)
        $past(srst) |-> trim_r == CAL_BYTE)
        else $error("trim not loaded from calibration at reset");
    a_busy_ready: assert property (@(posedge ref_clk) disable iff (srst)
        clkEn && start |=> !ready_r ##0 (busyCnt_r != '0) [*1])
        else $error("ready flag not low after a strobe");
    a_ready_busy_tie: assert property (@(posedge ref_clk) disable iff (srst)
        ready_r |-> busyCnt_r == '0)
        else $error("ready high while counting");
    a_data_drive: assert property (@(posedge ref_clk) disable iff (srst)
        dataOe_r && $past(clkEn) |-> !$past(pin_r.outEnableN) && $past(progMode_r))
        else $error("data driven without output enable low");
    a_cmd_load: assert property (@(posedge ref_clk) disable iff (srst)
        clkEn && progMode_r && xtalRise
        && {pin_r.pulseActionSelHi, pin_r.pulseActionSelLo} == fcpp_pkg::ACT_LOAD_CMD
        |=> cmd_r == $past(pin_r.data))
        else $error("command not loaded on crystal pulse");
    a_sig_read: assert property (@(posedge ref_clk) disable iff (srst)
        clkEn && cmd_r == fcpp_pkg::CMD_READ_SIG && !pin_r.byteHalfSelect
        && addrLo_r == fcpp_pkg::SIG_ADDR0 |=> dataOut_r == SIG_BYTE0)
        else $error("signature byte zero misread");
endmodule : fcpp_prog_port

//--- test/fcpp_prog_model.sv
`timescale 1ns/10ps

module fcpp_prog_model (
    // clock
    input  wire logic            ref_clk,
    // device side of the pins
    input  wire logic [7:0]      dataOut,
    input  wire logic            dataOe,
    input  wire logic            progReadyFlag,
    // driven pins
    output fcpp_pkg::fcpp_pins_s pins
);
    localparam int W = fcpp_pkg::PULSE_MIN_CYC; // every pulse and setup lasts at least this long

    initial pins = fcpp_pkg::PINS_IDLE;

    ////////////////////////////////////////////////////////////////////////////
    // wait edges, then step just past the edge so pins never race it
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick

    // entry pins all low before the programming voltage rises
    task automatic mode(input logic on);
        pins.bufferLoadStrobe = 1'b0;
        {pins.pulseActionSelHi, pins.pulseActionSelLo, pins.byteHalfSelect} = 3'h0;
        tick(W);
        pins.progEnable = on;
        tick(W);
    endtask : mode

    // crystal pulse with action code and data held around it
    task automatic act(input logic [1:0] a, input logic [7:0] d);
        {pins.pulseActionSelHi, pins.pulseActionSelLo} = a;
        pins.data = d;
        tick(W);
        pins.crystalInputOne = 1'b1;
        tick(W);
        pins.crystalInputOne = 1'b0;
        tick(W);
    endtask : act

    // write strobe; busy sampled shortly after, then ready awaited (bounded)
    task automatic wr(input logic [1:0] sel, output logic busy);
        int i;
        {pins.upperByteSelect, pins.byteHalfSelect} = sel;
        tick(W);
        pins.writeN = 1'b0;
        tick(10);
        busy = ~progReadyFlag;
        tick(W);
        pins.writeN = 1'b1;
        for (i = 0; i < 400 && progReadyFlag !== 1'b1; i++) tick(1);
        tick(W);
    endtask : wr

    // read: the data pins are driven inverted, so they show a changed value
    task automatic rd(input logic [1:0] sel, output logic [7:0] q);
        {pins.upperByteSelect, pins.byteHalfSelect} = sel;
        tick(W);
        pins.outEnableN = 1'b0;
        pins.data = ~pins.data;
        tick(W);
        q = (dataOe === 1'b1) ? dataOut : 8'hxx;
        pins.outEnableN = 1'b1;
        tick(W);
    endtask : rd

    // page buffer load strobe
    task automatic pg();
        pins.bufferLoadStrobe = 1'b1;
        tick(W);
        pins.bufferLoadStrobe = 1'b0;
        tick(W);
    endtask : pg
endmodule : fcpp_prog_model

//--- test/fuse_config_parallel_prog_port_tb.sv
`timescale 1ns/10ps

`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("[FAIL] %0t got %h expected %h", $time, got, exp); end end

module fuse_config_parallel_prog_port_tb;
    localparam logic [7:0] SIG0 = 8'h5a; // arbitrary identification value
    localparam logic [7:0] SIG1 = 8'h3b; // arbitrary identification value
    localparam logic [7:0] SIG2 = 8'h0c; // arbitrary identification value
    localparam logic [7:0] CAL  = 8'h3c;
    logic                  ref_clk;
    logic                  srst;
    logic [7:0]            dataOut;
    logic                  dataOe;
    logic                  ready;
    fcpp_pkg::fcpp_fuse_s  fuseLatch;
    fcpp_pkg::fcpp_flags_s fuseFlags;
    logic [7:0]            rcTrim;
    logic [7:0]            lockByte;
    logic                  memErase;
    logic                  eepErase;
    logic [7:0]            pageWord;
    fcpp_pkg::fcpp_pins_s  pins;
    logic [7:0]            sig [3] = '{SIG0, SIG1, SIG2};
    logic [7:0]            q;
    int                    n_tests = 0;
    int                    n_mismatch = 0;
    int                    nErase = 0;
    int                    nEep = 0;
    int                    cyc = 0;

    fcpp_prog_port #(.SIG_BYTE0(SIG0), .SIG_BYTE1(SIG1), .SIG_BYTE2(SIG2), .CAL_BYTE(CAL)) dut (
        .ref_clk(ref_clk), .srst(srst), .clkEn(1'b1), .pinsIn(pins), .dataOut(dataOut), .dataOe(dataOe),
        .progReadyFlag(ready), .fuseLatch(fuseLatch), .fuseFlags(fuseFlags), .rcTrimRegister(rcTrim),
        .lockByte(lockByte), .memEraseStrobe(memErase), .eepromEraseStrobe(eepErase), .pageWord(pageWord));

    fcpp_prog_model prog (.ref_clk(ref_clk), .dataOut(dataOut), .dataOe(dataOe), .progReadyFlag(ready),
        .pins(pins));

    ////////////////////////////////////////////////////////////////////////////
    // clock, erase strobe tallies and a hang limit well above the run length
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        nErase += int'(memErase === 1'b1);
        nEep += int'(eepErase === 1'b1);
        cyc++;
        if (cyc == 40000) begin
            n_mismatch++;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("compares %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim

    // reads low, high, extended and lock bytes; e is {lock, ext, high, low}
    task automatic rdfuse(input logic [31:0] e);
        int k;
        prog.act(fcpp_pkg::ACT_LOAD_CMD, fcpp_pkg::CMD_READ_FUSE);
        for (k = 0; k < 4; k++) begin
            prog.rd(2'(k), q);
            `CHK(q, e[8*k +: 8])
        end
        // the lock read leaves half select high, which would steer later loads to the high byte
        {prog.pins.upperByteSelect, prog.pins.byteHalfSelect} = fcpp_pkg::SEL_LOW;
    endtask : rdfuse

    // command, data, write strobe; busy must show even when refused
    task automatic wcmd(input logic [7:0] c, input logic [7:0] d, input logic [1:0] sel);
        logic busy;
        {prog.pins.upperByteSelect, prog.pins.byteHalfSelect} = fcpp_pkg::SEL_LOW; // fuse data is the low byte
        prog.act(fcpp_pkg::ACT_LOAD_CMD, c);
        prog.act(fcpp_pkg::ACT_LOAD_DATA, d);
        prog.wr(sel, busy);
        `CHK(busy, 1'b1)
        `CHK(ready, 1'b1)
    endtask : wcmd

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        srst = 1'b1;
        prog.tick(10);
        srst = 1'b0;
        prog.tick(5);
        `CHK(rcTrim, CAL)
        `CHK(fuseLatch, fcpp_pkg::FUSE_RESET)
        `CHK(fuseFlags, 10'h0f4)
        $display("test reset done");
        prog.mode(1'b1);
        prog.act(fcpp_pkg::ACT_LOAD_CMD, fcpp_pkg::CMD_READ_SIG);
        for (int i = 0; i < 3; i++) begin
            prog.act(fcpp_pkg::ACT_LOAD_ADDR, 8'(i));
            prog.rd(fcpp_pkg::SEL_LOW, q);
            `CHK(q, sig[i])
        end
        prog.act(fcpp_pkg::ACT_LOAD_ADDR, 8'h00);
        prog.rd(fcpp_pkg::SEL_HIGH, q);
        `CHK(q, CAL)
        `CHK(dataOe, 1'b0)
        rdfuse({8'hff, 8'hff, 8'h99, 8'h62});
        $display("test read done");
        wcmd(fcpp_pkg::CMD_WRITE_FUSE, 8'h22, fcpp_pkg::SEL_LOW);
        `CHK(fuseLatch.low, 8'h62)
        wcmd(fcpp_pkg::CMD_WRITE_FUSE, 8'h91, fcpp_pkg::SEL_HIGH);
        `CHK(fuseLatch.high[fcpp_pkg::HI_KEEP_EEPROM], 1'b0)
        wcmd(fcpp_pkg::CMD_CHIP_ERASE, 8'h00, fcpp_pkg::SEL_LOW);
        `CHK(nErase, 1)
        `CHK(nEep, 0)
        prog.pins.serialPath = 1'b1;
        wcmd(fcpp_pkg::CMD_WRITE_FUSE, 8'hb1, fcpp_pkg::SEL_HIGH);
        prog.pins.serialPath = 1'b0;
        rdfuse({8'hff, 8'hff, 8'h91, 8'h22});
        prog.pins.serialPath = 1'b1;
        prog.rd(fcpp_pkg::SEL_HIGH, q);
        `CHK(q, 8'hb1)
        prog.pins.serialPath = 1'b0;
        $display("test write done");
        wcmd(fcpp_pkg::CMD_WRITE_LOCK, 8'hfe, fcpp_pkg::SEL_LOW);
        `CHK(lockByte, 8'hfe)
        wcmd(fcpp_pkg::CMD_WRITE_FUSE, 8'hff, fcpp_pkg::SEL_LOW);
        rdfuse({8'hfe, 8'hff, 8'h91, 8'h22});
        prog.act(fcpp_pkg::ACT_LOAD_CMD, fcpp_pkg::CMD_READ_SIG);
        prog.act(fcpp_pkg::ACT_LOAD_ADDR, 8'h02);
        prog.rd(fcpp_pkg::SEL_LOW, q);
        `CHK(q, SIG2)
        prog.act(fcpp_pkg::ACT_LOAD_DATA, 8'ha5);
        prog.pg();
        `CHK(pageWord, 8'ha5)
        prog.mode(1'b0);
        `CHK(fuseLatch, 24'hff9122)
        `CHK(fuseFlags.clockPinDrive, 1'b1)
        $display("test lock and exit done");
        end_sim();
    end
endmodule : fuse_config_parallel_prog_port_tb
